// ### lrc_codec.sv
/*
 * lrc_codec: per-subsegment long-term prediction and pulse grid excitation
 * coder with its local decoder (inverse quantization, grid positioning,
 * long-term synthesis and the 120-sample reconstructed history).
 * Assumes a residual stream with valid/ready, lag and Q15 gain presented
 * with the first sample of each 40-sample subsegment, and a packer that
 * takes codes whenever their valid flags are high (no back-pressure).
 */
`timescale 1ns/1ns

module lrc_codec import lrc_pkg::*; (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic res_valid,
	input wire logic signed [15:0] res_sample,
	input wire logic [6:0] lag_in,
	input wire logic [15:0] gain_in,
	output logic res_ready_r,
	output logic ltr_valid_r,
	output logic signed [15:0] ltr_sample_r,
	output logic [6:0] lag_code_r,
	output logic [1:0] gain_code_r,
	output logic [1:0] grid_code_r,
	output logic [5:0] peak_code_r,
	output logic param_valid_r,
	output logic pulse_valid_r,
	output logic [3:0] pulse_idx_r,
	output logic [2:0] pulse_code_r,
	output logic recon_valid_r,
	output logic signed [15:0] recon_sample_r
);

	lrc_state_t state_r, state_nxt;
	logic [5:0] cnt_r;
	logic [1:0] ph_r;
	logic [6:0] lag_r;
	logic [14:0] gdec_r;
	logic [6:0] hptr_r;
	logic [1:0] grid_r;
	logic [14:0] xmax_r;
	logic signed [15:0] hist_r [HIST_LEN];
	logic signed [15:0] ebuf_r [SUBSEG_LEN];
	logic signed [15:0] xbuf_r [SUBSEG_LEN];
	logic signed [15:0] erec_r [SUBSEG_LEN];
	logic [35:0] energy_r [GRID_CANDS];
	logic signed [35:0] filt_acc;
	logic [1:0] best_c;
	int tap_pos;

	lrc_apq_if apq ();

	lrc_pulse_quant u_quant (
		.q (apq.quant)
	);

	// phase control
	wire take = res_valid && res_ready_r && (state_r == S_LOAD);
	wire phase_end = (state_nxt != state_r);
	wire step = (state_r == S_LOAD) ? take : (state_r != S_SEL);
	wire last40 = (cnt_r == 6'(SUBSEG_LEN - 1));
	wire last13 = (cnt_r == 6'(GRID_LEN - 1));

	// lag is kept in range so the history index can never leave the buffer
	wire [6:0] lag_clamp = (lag_in < LAG_MIN) ? LAG_MIN : (lag_in > LAG_MAX) ? LAG_MAX : lag_in;
	// lowest code whose threshold is not below the gain, else code 3
	wire [1:0] gcode_in = (gain_in <= GAIN_DEC_LVL0) ? 2'h0 :
		(gain_in <= GAIN_DEC_LVL1) ? 2'h1 :
		(gain_in <= GAIN_DEC_LVL2) ? 2'h2 : 2'h3;
	// the code is the lag itself, so decoding is the identity
	wire first = (cnt_r == 6'h00);
	// live inputs only while the first sample is offered; synthesis must use the latched copy
	wire use_in = first && (state_r == S_LOAD);
	wire [6:0] cur_lag = use_in ? lag_clamp : lag_r;
	wire [14:0] cur_gdec = use_in ? lrc_gain_level(gcode_in) : gdec_r;

	// circular history: oldest sample at hptr_r, so d'(k-N) sits at hptr+120+k-N
	wire [8:0] rd_sum = 9'(hptr_r) + 9'(HIST_LEN) + 9'(cnt_r) - 9'(cur_lag);
	wire [6:0] rd_idx = (rd_sum >= 9'(HIST_LEN)) ? 7'(rd_sum - 9'(HIST_LEN)) : 7'(rd_sum);
	wire [7:0] wr_sum = 8'(hptr_r) + 8'(cnt_r);
	wire [6:0] wr_idx = (wr_sum >= 8'(HIST_LEN)) ? 7'(wr_sum - 8'(HIST_LEN)) : 7'(wr_sum);
	wire [7:0] ptr_sum = 8'(hptr_r) + 8'(SUBSEG_LEN);
	wire [6:0] ptr_nxt = (ptr_sum >= 8'(HIST_LEN)) ? 7'(ptr_sum - 8'(HIST_LEN)) : 7'(ptr_sum);

	// estimate d'' = b' * d'(k-N), Q15 gain
	wire signed [15:0] hist_rd = hist_r[rd_idx];
	wire signed [15:0] gdec_s = $signed({1'b0, cur_gdec});
	wire signed [31:0] est_prod = hist_rd * gdec_s;
	wire signed [15:0] est = 16'(est_prod >>> Q15_SHIFT);
	wire signed [15:0] ltr_c = lrc_sat16(40'(res_sample) - 40'(est));
	wire signed [15:0] dnew_c = lrc_sat16(40'(erec_r[cnt_r]) + 40'(est));

	// block filter; taps beyond the subsegment see zero
	always_comb begin
		tap_pos = 0;
		filt_acc = '0;
		for (int i = 0; i < WF_TAPS_N; i++) begin
			tap_pos = int'(cnt_r) + WF_CENTRE - i;
			if (tap_pos >= 0 && tap_pos < SUBSEG_LEN)
				filt_acc = filt_acc + 36'(WF_TAPS[i]) * 36'(ebuf_r[6'(tap_pos)]);
		end
	end

	wire signed [15:0] filt_x = lrc_sat16(40'(filt_acc >>> WF_SHIFT));
	wire [31:0] filt_sq = 32'(filt_x) * 32'(filt_x);

	// candidate m takes k = m + 3i, i <= 12; k = 39 only belongs to m = 3
	wire in_ph = (cnt_r <= 6'(ph_r) + 6'(GRID_STEP * (GRID_LEN - 1)));
	wire in_m3 = (ph_r == 2'h0) && (cnt_r >= 6'(GRID_STEP));

	// strict compare keeps the lowest index on equal energies
	always_comb begin
		best_c = 2'h0;
		for (int m = 1; m < GRID_CANDS; m++) begin
			if (energy_r[m] > energy_r[best_c])
				best_c = 2'(m);
		end
	end

	// chosen-grid sample index and its magnitude, -32768 clipped to 32767
	wire [5:0] gsel_idx = 6'(grid_r) + cnt_r + cnt_r + cnt_r;
	wire signed [15:0] gsel_x = xbuf_r[gsel_idx];
	wire [15:0] gsel_abs_w = gsel_x[15] ? 16'(-gsel_x) : 16'(gsel_x);
	wire [14:0] gsel_abs = gsel_abs_w[15] ? 15'h7fff : gsel_abs_w[14:0];

	assign apq.xmax = xmax_r;
	assign apq.sample = gsel_x;

	// sequencing
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			S_LOAD: if (take && last40) state_nxt = S_FILT;
			S_FILT: if (last40) state_nxt = S_SEL;
			S_SEL: state_nxt = S_PEAK;
			S_PEAK: if (last13) state_nxt = S_QUANT;
			S_QUANT: if (last13) state_nxt = S_SYNTH;
			S_SYNTH: if (last40) state_nxt = S_LOAD;
			default: state_nxt = S_LOAD;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_r <= S_LOAD;
			cnt_r <= 6'h00;
			ph_r <= 2'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= phase_end ? 6'h00 : step ? cnt_r + 6'h01 : cnt_r;
			ph_r <= phase_end ? 2'h0 : !step ? ph_r : (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
		end
	end

	// subsegment parameters latched with the first sample
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			lag_r <= LAG_MIN;
			gdec_r <= GAIN_REC_LVL0;
			lag_code_r <= LAG_MIN;
			gain_code_r <= 2'h0;
		end else if (take && first) begin
			lag_r <= lag_clamp;
			gdec_r <= lrc_gain_level(gcode_in);
			lag_code_r <= lag_clamp;
			gain_code_r <= gcode_in;
		end
	end

	// input handshake and long-term residual out
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			res_ready_r <= 1'b0;
			ltr_valid_r <= 1'b0;
			ltr_sample_r <= 16'sh0000;
		end else begin
			res_ready_r <= (state_nxt == S_LOAD);
			ltr_valid_r <= take;
			if (take)
				ltr_sample_r <= ltr_c;
		end
	end

	// long-term residual buffer for the weighting filter
	always_ff @(posedge sys_clk) begin
		if (take)
			ebuf_r[cnt_r] <= ltr_c;
	end

	// filtered subsegment and per-candidate energies
	always_ff @(posedge sys_clk) begin
		if (state_r == S_FILT)
			xbuf_r[cnt_r] <= filt_x;
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n || (state_r == S_LOAD)) begin
			for (int m = 0; m < GRID_CANDS; m++)
				energy_r[m] <= 36'h0;
		end else if (state_r == S_FILT) begin
			if (in_ph)
				energy_r[ph_r] <= energy_r[ph_r] + 36'(filt_sq);
			if (in_m3)
				energy_r[GRID_CANDS - 1] <= energy_r[GRID_CANDS - 1] + 36'(filt_sq);
		end
	end

	// grid choice and block peak search
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			grid_r <= 2'h0;
			grid_code_r <= 2'h0;
			xmax_r <= 15'h0000;
		end else if (state_r == S_SEL) begin
			grid_r <= best_c;
			grid_code_r <= best_c;
			xmax_r <= 15'h0000;
		end else if ((state_r == S_PEAK) && (gsel_abs > xmax_r)) begin
			xmax_r <= gsel_abs;
		end
	end

	// excitation rebuilt with zeros between pulses; cleared before each grid
	always_ff @(posedge sys_clk) begin
		if (!reset_n || (state_r == S_SEL)) begin
			for (int k = 0; k < SUBSEG_LEN; k++)
				erec_r[k] <= 16'sh0000;
		end else if (state_r == S_QUANT) begin
			erec_r[gsel_idx] <= apq.recon;
		end
	end

	// pulse and parameter outputs toward the packer
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pulse_valid_r <= 1'b0;
			pulse_idx_r <= 4'h0;
			pulse_code_r <= 3'h0;
			peak_code_r <= 6'h00;
			param_valid_r <= 1'b0;
		end else begin
			pulse_valid_r <= (state_r == S_QUANT);
			param_valid_r <= (state_r == S_QUANT) && last13;
			if (state_r == S_QUANT) begin
				pulse_idx_r <= 4'(cnt_r);
				pulse_code_r <= apq.pulse_code;
			end
			if ((state_r == S_QUANT) && first)
				peak_code_r <= apq.peak_code;
		end
	end

	// synthesis: oldest history slot is overwritten, reads never reach it again
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			for (int h = 0; h < HIST_LEN; h++)
				hist_r[h] <= 16'sh0000;
		end else if (state_r == S_SYNTH) begin
			hist_r[wr_idx] <= dnew_c;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			hptr_r <= 7'h00;
			recon_valid_r <= 1'b0;
			recon_sample_r <= 16'sh0000;
		end else begin
			recon_valid_r <= (state_r == S_SYNTH);
			if (state_r == S_SYNTH)
				recon_sample_r <= dnew_c;
			if ((state_r == S_SYNTH) && last40)
				hptr_r <= ptr_nxt;
		end
	end

endmodule : lrc_codec

// ### lrc_pkg.sv
/*
 * lrc_pkg: constants, types and helper functions for the subsegment
 * long-term predictor and pulse grid excitation codec.
 * Assumes 16-bit signed samples and Q15 unsigned gains from upstream.
 */
package lrc_pkg;

	// sample format
	localparam int SAMP_W = 16;
	localparam logic signed [15:0] SAMP_MAX = 16'sh7fff;
	localparam logic signed [15:0] SAMP_MIN = 16'sh8000;

	// framing
	localparam int SUBSEG_LEN = 40;
	localparam int HIST_LEN = 120;
	localparam int GRID_LEN = 13;
	localparam int GRID_CANDS = 4;
	localparam int GRID_STEP = 3;

	// lag range, coded directly as a 7-bit value
	localparam logic [6:0] LAG_MIN = 7'h28;
	localparam logic [6:0] LAG_MAX = 7'h78;

	// gain decision levels 0.2, 0.5, 0.8 in Q15
	localparam logic [15:0] GAIN_DEC_LVL0 = 16'h199a;
	localparam logic [15:0] GAIN_DEC_LVL1 = 16'h4000;
	localparam logic [15:0] GAIN_DEC_LVL2 = 16'h6666;
	// gain reconstruction levels 0.10, 0.35, 0.65, 1.00 in Q15
	localparam logic [14:0] GAIN_REC_LVL0 = 15'h0ccd;
	localparam logic [14:0] GAIN_REC_LVL1 = 15'h2ccd;
	localparam logic [14:0] GAIN_REC_LVL2 = 15'h5333;
	localparam logic [14:0] GAIN_REC_LVL3 = 15'h7fff;
	localparam int Q15_SHIFT = 15;

	// weighting filter: 11 taps scaled by 2^13, centre tap 5
	localparam int WF_TAPS_N = 11;
	localparam int WF_CENTRE = 5;
	localparam int WF_SHIFT = 13;
	localparam logic signed [15:0] WF_TAPS [WF_TAPS_N] = '{
		16'shff7a, 16'shfe8a, 16'sh0000, 16'sh0806, 16'sh166d, 16'sh2000,
		16'sh166d, 16'sh0806, 16'sh0000, 16'shfe8a, 16'shff7a};

	// block peak coding: 16 linear codes of width 32, then octaves of 8 codes
	localparam int PEAK_LIN_SHIFT = 5;
	localparam int PEAK_LIN_CODES = 16;
	localparam int PEAK_OCT_CODES = 8;
	localparam int PEAK_OCT_FIRST = 9;
	localparam int PEAK_MSB = 14;

	// pulse quantizer: 8 levels, step 8192, lowest level -28672 (Q15)
	localparam int PULSE_STEP = 8192;
	localparam int PULSE_MIN_LVL = -28672;
	localparam int PULSE_HALF_LVLS = 4;

	typedef enum logic [5:0] {
		S_LOAD  = 6'h01,
		S_FILT  = 6'h02,
		S_SEL   = 6'h04,
		S_PEAK  = 6'h08,
		S_QUANT = 6'h10,
		S_SYNTH = 6'h20
	} lrc_state_t;

	// saturate a wide signed value into one sample
	function automatic logic signed [15:0] lrc_sat16(input logic signed [39:0] v);
		if (v > 40'(SAMP_MAX))
			return SAMP_MAX;
		else if (v < 40'(SAMP_MIN))
			return SAMP_MIN;
		else
			return v[15:0];
	endfunction : lrc_sat16

	// gain code to Q15 reconstruction level
	function automatic logic [14:0] lrc_gain_level(input logic [1:0] code);
		case (code)
			2'h0: return GAIN_REC_LVL0;
			2'h1: return GAIN_REC_LVL1;
			2'h2: return GAIN_REC_LVL2;
			default: return GAIN_REC_LVL3;
		endcase
	endfunction : lrc_gain_level

endpackage : lrc_pkg

// ### lrc_apq_if.sv
/*
 * lrc_apq_if: signals between the subsegment sequencer and the
 * adaptive pulse quantizer. Purely combinational path, no clock.
 */
`timescale 1ns/1ns
interface lrc_apq_if;
	logic [14:0] xmax;
	logic signed [15:0] sample;
	logic [5:0] peak_code;
	logic [14:0] peak_dec;
	logic [2:0] pulse_code;
	logic signed [15:0] recon;

	modport ctrl (output xmax, output sample, input peak_code, input peak_dec, input pulse_code, input recon);
	modport quant (input xmax, input sample, output peak_code, output peak_dec, output pulse_code, output recon);
endinterface : lrc_apq_if

// ### lrc_pulse_quant.sv
/*
 * lrc_pulse_quant: block peak coder/decoder and 3-bit pulse quantizer
 * with inverse quantization and denormalization, all combinational.
 * Assumes |sample| never exceeds xmax, which the sequencer guarantees.
 */
`timescale 1ns/1ns
module lrc_pulse_quant import lrc_pkg::*; (
	lrc_apq_if.quant q
);

	logic [5:0] pcode_c;
	logic [14:0] pdec_c;
	logic [2:0] mant_c;
	logic [2:0] code_c;
	int level_c;

	// peak code: linear below 512, then octaves; decoded peak is interval top
	always_comb begin
		pcode_c = {1'b0, q.xmax[9:5]};
		pdec_c = {q.xmax[14:5], 5'h1f};
		mant_c = 3'h0;
		for (int b = PEAK_OCT_FIRST; b <= PEAK_MSB; b++) begin
			if (q.xmax[b]) begin
				mant_c = 3'(q.xmax >> (b - 3));
				pcode_c = 6'(PEAK_LIN_CODES + PEAK_OCT_CODES * (b - PEAK_OCT_FIRST) + int'(mant_c));
				pdec_c = 15'(((PEAK_OCT_CODES + 1 + int'(mant_c)) << (b - 3)) - 1);
			end
		end
	end

	// x/peak scaled by 2^15 falls in step j when 4x >= j*peak; no divider needed
	always_comb begin
		code_c = 3'h0;
		for (int j = 1 - PULSE_HALF_LVLS; j < PULSE_HALF_LVLS; j++) begin
			if (4 * int'(q.sample) >= j * int'(pdec_c))
				code_c = code_c + 3'h1;
		end
	end

	// level in Q15 times decoded peak, back to sample scale
	always_comb begin
		level_c = PULSE_MIN_LVL + int'(code_c) * PULSE_STEP;
	end

	assign q.peak_code = pcode_c;
	assign q.peak_dec = pdec_c;
	assign q.pulse_code = code_c;
	assign q.recon = 16'((level_c * int'(pdec_c)) >>> Q15_SHIFT);

endmodule : lrc_pulse_quant

// ### lrc_codec_properties.sv
/* lrc_codec_properties: timing and code checks on the codec's top ports.
   Assumes one clock domain and the synchronous active-low reset. */
`timescale 1ns/1ns
module lrc_codec_properties import lrc_pkg::*; (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic res_valid,
	input wire logic [6:0] lag_in,
	input wire logic [15:0] gain_in,
	input wire logic res_ready_r,
	input wire logic ltr_valid_r,
	input wire logic [6:0] lag_code_r,
	input wire logic [1:0] gain_code_r,
	input wire logic [1:0] grid_code_r,
	input wire logic [5:0] peak_code_r,
	input wire logic param_valid_r,
	input wire logic pulse_valid_r,
	input wire logic [3:0] pulse_idx_r,
	input wire logic recon_valid_r
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	logic [5:0] take_cnt_r;
	logic [5:0] recon_run_r;
	// take decode and the gain code that the thresholds call for
	wire take = res_valid && res_ready_r;
	wire [1:0] gain_exp = (gain_in <= GAIN_DEC_LVL0) ? 2'h0 : (gain_in <= GAIN_DEC_LVL1) ? 2'h1 :
		(gain_in <= GAIN_DEC_LVL2) ? 2'h2 : 2'h3;
	// sample position in the subsegment, length of the recon run
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			take_cnt_r <= 6'h00;
			recon_run_r <= 6'h00;
		end else begin
			if (take)
				take_cnt_r <= (take_cnt_r == 6'h27) ? 6'h00 : take_cnt_r + 6'h01;
			recon_run_r <= recon_valid_r ? recon_run_r + 6'h01 : 6'h00;
		end
	end
	sequence s_last_take;
		take && take_cnt_r == 6'h27;
	endsequence
	sequence s_pulses_then_recon;
		##56 (pulse_valid_r && pulse_idx_r == 4'h0) ##13 recon_valid_r ##39 (recon_valid_r && res_ready_r)
		##1 !recon_valid_r;
	endsequence
	property p_ready_drop; s_last_take |=> !res_ready_r ##106 !res_ready_r; endproperty
	property p_timeline; s_last_take |-> s_pulses_then_recon; endproperty
	property p_ltr_take; take |=> ltr_valid_r; endproperty
	property p_ltr_only; ltr_valid_r |-> $past(take); endproperty
	property p_idx_step;
		pulse_valid_r && pulse_idx_r != 4'hc |=> pulse_valid_r && pulse_idx_r == $past(pulse_idx_r) + 4'h1;
	endproperty
	property p_param_last; param_valid_r |-> pulse_valid_r && pulse_idx_r == 4'hc; endproperty
	property p_codes_hold;
		pulse_valid_r && pulse_idx_r != 4'h0 |-> $stable(grid_code_r) && $stable(peak_code_r);
	endproperty
	property p_recon_len; $fell(recon_valid_r) |-> recon_run_r == 6'h28; endproperty
	property p_lag_code;
		take && take_cnt_r == 6'h00 && lag_in >= LAG_MIN && lag_in <= LAG_MAX |=> lag_code_r == $past(lag_in);
	endproperty
	property p_lag_range; lag_code_r >= LAG_MIN && lag_code_r <= LAG_MAX; endproperty
	property p_gain_code; take && take_cnt_r == 6'h00 |=> gain_code_r == $past(gain_exp); endproperty
	a_ready_drop: assert property (p_ready_drop) else $error("ready back too soon");
	a_timeline: assert property (p_timeline) else $error("pulse or recon timing off");
	a_ltr_take: assert property (p_ltr_take) else $error("no residual after take");
	a_ltr_only: assert property (p_ltr_only) else $error("residual without take");
	a_idx_step: assert property (p_idx_step) else $error("pulse index skipped");
	a_param_last: assert property (p_param_last) else $error("param valid misplaced");
	a_codes_hold: assert property (p_codes_hold) else $error("codes moved mid pulses");
	a_recon_len: assert property (p_recon_len) else $error("recon run not 40");
	a_lag_code: assert property (p_lag_code) else $error("lag code differs");
	a_lag_range: assert property (p_lag_range) else $error("lag code out of range");
	a_gain_code: assert property (p_gain_code) else $error("gain code wrong");
endmodule : lrc_codec_properties

bind lrc_codec lrc_codec_properties u_props (.sys_clk(sys_clk), .reset_n(reset_n), .res_valid(res_valid),
	.lag_in(lag_in), .gain_in(gain_in), .res_ready_r(res_ready_r), .ltr_valid_r(ltr_valid_r),
	.lag_code_r(lag_code_r), .gain_code_r(gain_code_r), .grid_code_r(grid_code_r), .peak_code_r(peak_code_r),
	.param_valid_r(param_valid_r), .pulse_valid_r(pulse_valid_r), .pulse_idx_r(pulse_idx_r),
	.recon_valid_r(recon_valid_r));

// ### lrc_res_source.sv
/* lrc_res_source: upstream residual source, one 40-sample subsegment per go.
   Assumes go is raised for one cycle; drives codec inputs at falling edges, raises busy at a rising edge. */
`timescale 1ns/1ns
module lrc_res_source import lrc_pkg::*; (
	input wire logic sys_clk,
	input wire logic go,
	input wire logic slow,
	input wire logic signed [15:0] samp [SUBSEG_LEN],
	input wire logic [6:0] lag,
	input wire logic [15:0] gain,
	input wire logic res_ready_r,
	output logic res_valid,
	output logic signed [15:0] res_sample,
	output logic [6:0] lag_in,
	output logic [15:0] gain_in,
	output logic busy
);
	int k;
	// hold each sample until taken; idle lines show scrambled values
	initial begin
		res_valid = 1'b0;
		res_sample = 16'h0000;
		lag_in = 7'h28;
		gain_in = 16'h0000;
		busy = 1'b0;
		forever begin
			@(posedge sys_clk);
			if (go) begin
				busy = 1'b1;
				@(negedge sys_clk);
				for (k = 0; k < SUBSEG_LEN; k++) begin
					res_valid = 1'b1;
					res_sample = samp[k];
					lag_in = (k == 0) ? lag : ~lag;  // only the first sample carries lag and gain
					gain_in = (k == 0) ? gain : ~gain;
					do @(posedge sys_clk); while (res_ready_r !== 1'b1);
					@(negedge sys_clk);
					if (slow || k == SUBSEG_LEN - 1) begin
						res_valid = 1'b0;
						res_sample = ~samp[k];
					end
					if (slow)
						@(negedge sys_clk);
				end
				busy = 1'b0;
			end
		end
	end
endmodule : lrc_res_source

// ### lrc_codec_tb.sv
/* lrc_codec_tb: self-checking bench for lrc_codec with a residual source.
   Assumes the codec's registered timing; inputs change at falling edges. */
`timescale 1ns/1ns
module lrc_codec_tb import lrc_pkg::*; ;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic go = 1'b0;
	logic slow = 1'b0;
	logic signed [15:0] samp [SUBSEG_LEN];
	logic [6:0] lag = 7'h28;
	logic [15:0] gain = 16'h0000;
	logic res_valid, res_ready_r, ltr_valid_r, param_valid_r, pulse_valid_r, recon_valid_r, busy;
	logic signed [15:0] res_sample, ltr_sample_r, recon_sample_r;
	logic [6:0] lag_in, lag_code_r;
	logic [15:0] gain_in;
	logic [1:0] gain_code_r, grid_code_r;
	logic [5:0] peak_code_r;
	logic [3:0] pulse_idx_r;
	logic [2:0] pulse_code_r;
	logic [15:0] ltr_q [64];
	logic [15:0] rec_q [64];
	logic [2:0] pul_q [16];
	int lc, rc, fail_count, checks, cyc;

	initial forever #2 sys_clk = ~sys_clk;

	lrc_codec dut (.sys_clk(sys_clk), .reset_n(reset_n), .res_valid(res_valid), .res_sample(res_sample),
		.lag_in(lag_in), .gain_in(gain_in), .res_ready_r(res_ready_r), .ltr_valid_r(ltr_valid_r),
		.ltr_sample_r(ltr_sample_r), .lag_code_r(lag_code_r), .gain_code_r(gain_code_r),
		.grid_code_r(grid_code_r), .peak_code_r(peak_code_r), .param_valid_r(param_valid_r),
		.pulse_valid_r(pulse_valid_r), .pulse_idx_r(pulse_idx_r), .pulse_code_r(pulse_code_r),
		.recon_valid_r(recon_valid_r), .recon_sample_r(recon_sample_r));
	lrc_res_source src (.sys_clk(sys_clk), .go(go), .slow(slow), .samp(samp), .lag(lag), .gain(gain),
		.res_ready_r(res_ready_r), .res_valid(res_valid), .res_sample(res_sample), .lag_in(lag_in),
		.gain_in(gain_in), .busy(busy));

	// collect downstream output; cycle ceiling cuts a hang short
	always @(posedge sys_clk) begin
		cyc++;
		if (ltr_valid_r === 1'b1) ltr_q[lc++] = ltr_sample_r;
		if (recon_valid_r === 1'b1) rec_q[rc++] = recon_sample_r;
		if (pulse_valid_r === 1'b1) pul_q[pulse_idx_r] = pulse_code_r;
		if (cyc == 20000) begin
			fail_count++;
			close_out();
		end
	end

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic close_out();
		$display("checks %0d, fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	task automatic do_reset();
		foreach (samp[i]) samp[i] = 16'h0000;
		reset_n = 1'b0;
		repeat (6) @(negedge sys_clk);
		chk("lag code in reset", 16'(lag_code_r), 16'h0028);
		reset_n = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk("ready after reset", 16'(res_ready_r), 16'h0001);
	endtask : do_reset

	// one subsegment through the source, bounded wait for all recon
	task automatic run_sub(input logic [6:0] l, input logic [15:0] g, input logic s);
		int n;
		lag = l;
		gain = g;
		slow = s;
		lc = 0;
		rc = 0;
		go = 1'b1;
		@(negedge sys_clk);
		go = 1'b0;
		for (n = 0; n < 600 && rc < 40; n++) @(negedge sys_clk);
		chk("recon count", 16'(rc), 16'h0028);
		chk("source done", 16'(busy), 16'h0000);
	endtask : run_sub

	// lag clamp and gain thresholds on both sides of each level
	task automatic t_codes();
		logic [6:0] lags [6] = '{7'h28, 7'h78, 7'h27, 7'h79, 7'h50, 7'h29};
		logic [6:0] lexp [6] = '{7'h28, 7'h78, 7'h28, 7'h78, 7'h50, 7'h29};
		logic [15:0] gains [6] = '{16'h199a, 16'h199b, 16'h4000, 16'h4001, 16'h6666, 16'h6667};
		int j;
		for (j = 0; j < 6; j++) begin
			run_sub(lags[j], gains[j], 1'b0);
			chk("lag code", 16'(lag_code_r), 16'(lexp[j]));
			chk("gain code", 16'(gain_code_r), 16'((j + 1) / 2));
		end
	endtask : t_codes

	// single pulse at k=20 with zero history: grid 2, all other pulses at code 4
	task automatic t_impulse(input logic [15:0] amp, input logic [5:0] pc, input logic [2:0] p6,
		input logic [15:0] r4, input logic [15:0] r20);
		int k;
		do_reset();
		samp[20] = amp;
		run_sub(7'h28, 16'h0000, 1'b0);
		chk("grid code", 16'(grid_code_r), 16'h0002);
		chk("peak code", 16'(peak_code_r), 16'(pc));
		for (k = 0; k < 13; k++)
			chk("pulse code", 16'(pul_q[k]), (k == 6) ? 16'(p6) : 16'h0004);
		for (k = 0; k < 40; k++) begin
			chk("residual", ltr_q[k], (k == 20) ? amp : 16'h0000);
			chk("recon", rec_q[k], (k % 3 != 2) ? 16'h0000 : (k == 20) ? r20 : r4);
		end
	endtask : t_impulse

	// silent subsegment, then estimates from 40 and 80 samples back
	task automatic t_history();
		int j, k;
		do_reset();
		run_sub(7'h28, 16'h0000, 1'b0);
		chk("grid code on tie", 16'(grid_code_r), 16'h0000);
		for (k = 0; k < 40; k++)
			chk("recon", rec_q[k], (k % 3 == 0 && k < 39) ? 16'h0003 : 16'h0000);
		for (j = 0; j < 2; j++) begin
			run_sub((j == 0) ? 7'h28 : 7'h50, 16'h8000, j == 0);
			chk("gain code", 16'(gain_code_r), 16'h0003);
			for (k = 0; k < 40; k++)
				chk("residual", ltr_q[k], (k % 3 == 0 && k < 39) ? 16'hfffe : 16'h0000);
		end
	endtask : t_history

	initial begin
		do_reset();
		t_codes();
		t_impulse(16'h03e8, 6'h17, 3'h7, 16'h007f, 16'h037f);
		t_impulse(16'hfc18, 6'h17, 3'h0, 16'h007f, 16'hfc80);
		t_impulse(16'h0400, 6'h18, 3'h7, 16'h008f, 16'h03ef);
		t_history();
		close_out();
	end
endmodule : lrc_codec_tb
